// ---- rtl/prc_pkg.sv ----
// Types of the rail configuration field set and its sequencer state.
// Assumes prc_regs.svh for all numeric constants.
package prc_pkg;

    typedef enum logic [1:0] {SEQ_OFF, SEQ_UP, SEQ_ON, SEQ_DOWN} prc_seq_e;

    // Whole configuration field set, fuse image and live copy alike
    typedef struct packed {
        logic [3:0]       fb_div3;
        logic [3:0][6:0]  ref_code;
        logic [3:0]       rail_enable;
        logic [1:0]       uvlo_sel;
        logic             output_port_level;
        logic [1:0]       switch_rate_select;
        logic             sd_reverse;
        logic [4:0]       addr_hi;
        logic [1:0]       multipin_function_select;
        logic [2:0]       good_indicator_delay;
        logic             gang34;
        logic             gang12;
        logic [3:0][1:0]  ilim_sel;
    } prc_cfg_s;

    // All state of the block
    typedef struct packed {
        logic             loaded;
        prc_cfg_s         cfg;
        logic [3:0][10:0] ref_mv;
        logic [7:0]       step_cnt;
        prc_seq_e         seq;
        logic [1:0]       seq_idx;
        logic [31:0]      slot_cnt;
        logic [3:0]       rail_on;
        logic [31:0]      pg_cnt;
        logic             pg_good;
        logic [9:0]       sync_cnt;
        logic             sync_lvl;
        logic             pin_oe;
    } prc_st_s;

endpackage : prc_pkg

// ---- rtl/prc_rail_config.sv ----
// Configuration field set of a four-rail step-down power device, with the
// reference ramps, power sequencer, power-good timer and multipurpose pin.
// Assumes fuse image and write data are synchronous to i_ref_clk.
`timescale 1ns/10ps
`include "prc_regs.svh"

module prc_rail_config
    import prc_pkg::*;
#(
    parameter logic [31:0] SLOT_CYC = `PRC_US_TO_CYC(`PRC_SLOT_US),
    parameter logic [31:0] PG_CYC_0 = `PRC_US_TO_CYC(`PRC_PG_0_US),
    parameter logic [31:0] PG_CYC_1 = `PRC_US_TO_CYC(`PRC_PG_1_US),
    parameter logic [31:0] PG_CYC_2 = `PRC_US_TO_CYC(`PRC_PG_2_US),
    parameter logic [31:0] PG_CYC_3 = `PRC_US_TO_CYC(`PRC_PG_3_US),
    parameter logic [31:0] PG_CYC_4 = `PRC_US_TO_CYC(`PRC_PG_4_US),
    parameter logic        ADDR_A6  = 1'b1  // Arbitrary top address bit
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_b,
    input  wire prc_cfg_s         i_fuse_cfg,       // Fuse image
    input  wire logic             i_cfg_wr,         // Write strobe from serial slave
    input  wire prc_cfg_s         i_cfg_wdata,      // Field set to write
    input  wire logic             i_enable_sync,    // Enable/sync input level
    input  wire logic [3:0]       i_rail_ok,        // Rail output in regulation
    input  wire logic             i_mp_in,          // Multipurpose pin level
    output prc_cfg_s              o_cfg,            // Live field set for readback
    output logic      [3:0]       o_rail_run,
    output logic      [3:0]       o_fb_div3,
    output logic      [3:0][10:0] o_ref_target_mv,
    output logic      [3:0][10:0] o_ref_mv,         // Ramping internal reference
    output logic      [3:0][12:0] o_vout_mv,        // Output setpoint, tripled with divided FB
    output logic      [3:0][14:0] o_ilim_ma,
    output logic      [13:0]      o_uvlo_rise_mv,
    output logic      [10:0]      o_switch_khz,
    output logic      [6:0]       o_slave_addr,
    output logic                  o_power_good,
    output logic                  o_mp_out,
    output logic                  o_mp_oe
);

    prc_st_s st_reg;
    prc_st_s st_next;

    // Reference target from a 7-bit code
    function automatic logic [10:0] ref_of(input logic [6:0] code);
        ref_of = `PRC_REF_BASE_MV + 11'(code) * `PRC_REF_STEP_MV;
    endfunction : ref_of

    // Rail whose settings a rail follows while ganged
    function automatic logic [1:0] leader(input logic [1:0] r, input prc_cfg_s c);
        leader = r;
        if (r == 2'h1 && c.gang12) begin
            leader = 2'h0;
        end
        if (r == 2'h3 && c.gang34) begin
            leader = 2'h2;
        end
    endfunction : leader

    // Valley current limit of a select code
    function automatic logic [13:0] ilim_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: ilim_of = `PRC_ILIM_0_MA;
            2'h1: ilim_of = `PRC_ILIM_1_MA;
            2'h2: ilim_of = `PRC_ILIM_2_MA;
            2'h3: ilim_of = `PRC_ILIM_3_MA;
        endcase
    endfunction : ilim_of

    // Power-good delay in cycles; unused codes take the longest delay
    function automatic logic [31:0] pg_of(input logic [2:0] sel);
        unique case (sel)
            3'h0:    pg_of = PG_CYC_0;
            3'h1:    pg_of = PG_CYC_1;
            3'h2:    pg_of = PG_CYC_2;
            3'h3:    pg_of = PG_CYC_3;
            default: pg_of = PG_CYC_4;
        endcase
    endfunction : pg_of

    // Sync clock half period for the common switching rate
    function automatic logic [9:0] half_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: half_of = 10'(`PRC_HALF_CYC(`PRC_SWITCH_RATE_SELECT_0_KHZ));
            2'h1: half_of = 10'(`PRC_HALF_CYC(`PRC_SWITCH_RATE_SELECT_1_KHZ));
            2'h2: half_of = 10'(`PRC_HALF_CYC(`PRC_SWITCH_RATE_SELECT_2_KHZ));
            2'h3: half_of = 10'(`PRC_HALF_CYC(`PRC_SWITCH_RATE_SELECT_3_KHZ));
        endcase
    endfunction : half_of

    // Effective per-rail settings after ganging
    logic [3:0]       en_eff;
    logic [3:0][10:0] tgt_eff;
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            en_eff[r]  = st_reg.cfg.rail_enable[leader(2'(r), st_reg.cfg)];
            tgt_eff[r] = ref_of(st_reg.cfg.ref_code[leader(2'(r), st_reg.cfg)]);
        end
    end

    // Next state of the whole block
    always_comb begin
        logic pg_raw;
        logic ramp_tick;
        pg_raw    = 1'b0;
        ramp_tick = 1'b0;
        st_next   = st_reg;

        // A write landing on the load edge is dropped on purpose: the fuse image wins,
        // so the host never sees a half-loaded field set. Follower rails start at
        // their leader's target so a fuse-ganged pair does not ramp apart.
        // Fuse load once after reset release, then host writes override
        if (!st_reg.loaded) begin
            st_next.loaded = 1'b1;
            st_next.cfg    = i_fuse_cfg;
            for (int r = 0; r < 4; r++) begin
                st_next.ref_mv[r] = ref_of(i_fuse_cfg.ref_code[leader(2'(r), i_fuse_cfg)]);
            end
        end else if (i_cfg_wr) begin
            st_next.cfg = i_cfg_wdata;
        end

        // Reference ramp, 1mV per step at the fixed slew
        if (st_reg.step_cnt == 8'(`PRC_RAMP_STEP_CYC - 1)) begin
            st_next.step_cnt = 8'h00;
            ramp_tick        = 1'b1;
        end else begin
            st_next.step_cnt = st_reg.step_cnt + 8'h01;
        end
        for (int r = 0; r < 4; r++) begin
            if (st_reg.loaded && ramp_tick) begin
                if (st_reg.ref_mv[r] < tgt_eff[r]) begin
                    st_next.ref_mv[r] = st_reg.ref_mv[r] + 11'h001;
                end else if (st_reg.ref_mv[r] > tgt_eff[r]) begin
                    st_next.ref_mv[r] = st_reg.ref_mv[r] - 11'h001;
                end
            end
        end

        // Power sequencer: rails on 1 to 4, off together or 4 to 1
        if (st_reg.slot_cnt != 32'h0) begin
            st_next.slot_cnt = st_reg.slot_cnt - 32'h1;
        end
        unique case (st_reg.seq)
            SEQ_OFF: begin
                st_next.rail_on = 4'h0;
                if (i_enable_sync && st_reg.loaded) begin
                    st_next.seq      = SEQ_UP;
                    st_next.seq_idx  = 2'h0;
                    st_next.slot_cnt = SLOT_CYC;
                end
            end
            SEQ_UP, SEQ_ON: begin
                if (!i_enable_sync) begin
                    if (st_reg.cfg.sd_reverse) begin
                        st_next.seq      = SEQ_DOWN;
                        st_next.seq_idx  = 2'h3;
                        st_next.slot_cnt = SLOT_CYC;
                    end else begin
                        st_next.seq     = SEQ_OFF;
                        st_next.rail_on = 4'h0;
                    end
                end else if (st_reg.seq == SEQ_UP && st_reg.slot_cnt == 32'h0) begin
                    st_next.rail_on[st_reg.seq_idx] = 1'b1;
                    st_next.seq_idx  = st_reg.seq_idx + 2'h1;
                    st_next.slot_cnt = SLOT_CYC;
                    if (st_reg.seq_idx == 2'h3) begin
                        st_next.seq = SEQ_ON;
                    end
                end
            end
            SEQ_DOWN: begin
                if (st_reg.slot_cnt == 32'h0) begin
                    st_next.rail_on[st_reg.seq_idx] = 1'b0;
                    st_next.seq_idx  = st_reg.seq_idx - 2'h1;
                    st_next.slot_cnt = SLOT_CYC;
                    if (st_reg.seq_idx == 2'h0) begin
                        st_next.seq = SEQ_OFF;
                    end
                end
            end
        endcase

        // The counter restarts whenever a running rail leaves regulation, so a
        // short dropout always costs the full selected delay again.
        // Power good after the selected delay with all running rails in regulation
        pg_raw = (st_reg.seq == SEQ_ON);
        for (int r = 0; r < 4; r++) begin
            if (st_reg.rail_on[r] && en_eff[r] && !i_rail_ok[r]) begin
                pg_raw = 1'b0;
            end
        end
        if (!pg_raw) begin
            st_next.pg_cnt  = 32'h0;
            st_next.pg_good = 1'b0;
        end else if (st_reg.pg_cnt >= pg_of(st_reg.cfg.good_indicator_delay)) begin
            st_next.pg_good = 1'b1;
        end else begin
            st_next.pg_cnt = st_reg.pg_cnt + 32'h1;
        end

        // Free-running so a rate change never leaves the pin stuck at one level
        // Sync clock divider at the common switching rate
        if (st_reg.sync_cnt >= half_of(st_reg.cfg.switch_rate_select) - 10'h001) begin
            st_next.sync_cnt = 10'h000;
            st_next.sync_lvl = !st_reg.sync_lvl;
        end else begin
            st_next.sync_cnt = st_reg.sync_cnt + 10'h001;
        end

        // Taken from the next state so the pin agrees with o_cfg in every cycle
        // Open-drain pin pull-down by function
        unique case (st_next.cfg.multipin_function_select)
            `PRC_MP_ADDR: st_next.pin_oe = 1'b0;
            `PRC_MP_GOOD: st_next.pin_oe = !st_next.pg_good;
            `PRC_MP_PORT: st_next.pin_oe = !st_next.cfg.output_port_level;
            `PRC_MP_SYNC: st_next.pin_oe = !st_next.sync_lvl;
        endcase
    end

    // Reset clears everything; the fuse image is copied in on the first edge after
    // State register
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Per-rail outputs, follower rails take their leader's settings but keep their own run slot and ramp
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            o_rail_run[r]      = st_reg.rail_on[r] && en_eff[r];
            o_fb_div3[r]       = st_reg.cfg.fb_div3[leader(2'(r), st_reg.cfg)];
            o_ref_target_mv[r] = tgt_eff[r];
            o_ref_mv[r]        = st_reg.ref_mv[r];
            // Divided feedback triples the output and its ramp rate
            o_vout_mv[r]       = o_fb_div3[r] ? 13'(st_reg.ref_mv[r]) * 13'(`PRC_OUT_MULT)
                                              : 13'(st_reg.ref_mv[r]);
            o_ilim_ma[r] = 15'(ilim_of(st_reg.cfg.ilim_sel[leader(2'(r), st_reg.cfg)]));
        end
        if (st_reg.cfg.gang12) begin
            o_ilim_ma[0] = 15'(ilim_of(st_reg.cfg.ilim_sel[0])) << 1;
            o_ilim_ma[1] = o_ilim_ma[0];
        end
        if (st_reg.cfg.gang34) begin
            o_ilim_ma[2] = 15'(ilim_of(st_reg.cfg.ilim_sel[2])) << 1;
            o_ilim_ma[3] = o_ilim_ma[2];
        end
    end

    // Common settings decode
    always_comb begin
        unique case (st_reg.cfg.uvlo_sel)
            2'h0: o_uvlo_rise_mv = `PRC_UVLO_0_MV;
            2'h1: o_uvlo_rise_mv = `PRC_UVLO_1_MV;
            2'h2: o_uvlo_rise_mv = `PRC_UVLO_2_MV;
            2'h3: o_uvlo_rise_mv = `PRC_UVLO_3_MV;
        endcase
        unique case (st_reg.cfg.switch_rate_select)
            2'h0: o_switch_khz = 11'(`PRC_SWITCH_RATE_SELECT_0_KHZ);
            2'h1: o_switch_khz = 11'(`PRC_SWITCH_RATE_SELECT_1_KHZ);
            2'h2: o_switch_khz = 11'(`PRC_SWITCH_RATE_SELECT_2_KHZ);
            2'h3: o_switch_khz = 11'(`PRC_SWITCH_RATE_SELECT_3_KHZ);
        endcase
    end

    // Slave address: A5..A1 from the field, A0 from the pin in address mode
    assign o_slave_addr = {ADDR_A6, st_reg.cfg.addr_hi,
                           (st_reg.cfg.multipin_function_select == `PRC_MP_ADDR)
                           && i_mp_in};

    assign o_cfg        = st_reg.cfg;
    assign o_power_good = st_reg.pg_good;
    assign o_mp_out     = 1'b0;  // Open drain only ever pulls low
    assign o_mp_oe      = st_reg.pin_oe;

endmodule : prc_rail_config

// ---- rtl/prc_regs.svh ----
// Constants of the rail configuration field set: codes, values and timing.
// Assumes a 250 MHz reference clock; included by the design.
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH

// Clock period and reference ramp
`define PRC_CLK_NS          4
`define PRC_REF_BASE_MV     11'h226
`define PRC_REF_STEP_MV     11'h00A
`define PRC_SLEW_UV_PER_US  2600
`define PRC_STEP_UV         1000
`define PRC_RAMP_STEP_CYC   ((`PRC_STEP_UV * 1000 / `PRC_SLEW_UV_PER_US) / `PRC_CLK_NS)
`define PRC_OUT_MULT        2'h3

// Multipurpose pin function codes
`define PRC_MP_ADDR         2'h0
`define PRC_MP_GOOD         2'h1
`define PRC_MP_PORT         2'h2
`define PRC_MP_SYNC         2'h3

// Input undervoltage rising thresholds in mV
`define PRC_UVLO_0_MV       14'h0DAC
`define PRC_UVLO_1_MV       14'h1194
`define PRC_UVLO_2_MV       14'h16A8
`define PRC_UVLO_3_MV       14'h2134

// Switching rates in kHz, and sync half periods derived from them
`define PRC_SWITCH_RATE_SELECT_0_KHZ      533
`define PRC_SWITCH_RATE_SELECT_1_KHZ      800
`define PRC_SWITCH_RATE_SELECT_2_KHZ      1060
`define PRC_SWITCH_RATE_SELECT_3_KHZ      1600
`define PRC_HALF_CYC(k)     ((500000 / (k)) / `PRC_CLK_NS)

// Power-good delays in us
`define PRC_PG_0_US         200
`define PRC_PG_1_US         5000
`define PRC_PG_2_US         25000
`define PRC_PG_3_US         75000
`define PRC_PG_4_US         200000
`define PRC_US_TO_CYC(u)    ((u) * 1000 / `PRC_CLK_NS)

// Valley current limits in mA per select code
`define PRC_ILIM_0_MA       14'h07D0
`define PRC_ILIM_1_MA       14'h0BB8
`define PRC_ILIM_2_MA       14'h1068
`define PRC_ILIM_3_MA       14'h1388

// Sequencer slot between rail turn-on/turn-off steps
`define PRC_SLOT_US         1000

`endif

// ---- tb/prc_host_model.sv ----
// Host that writes whole field sets into the block.
// Assumes writes start on a rising edge of i_ref_clk.
`timescale 1ns/10ps
module prc_host_model
    import prc_pkg::*;
#(
    parameter logic [3:0] AVS_RAILS = 4'h8  // Rails under voltage scaling
) (
    input  wire logic     i_ref_clk,
    output logic          o_cfg_wr,
    output prc_cfg_s      o_cfg_wdata
);
    initial o_cfg_wr = 1'b0;
    initial o_cfg_wdata = '0;
    // Optional idle gap, one strobe cycle, then data scrambled
    task automatic write(input prc_cfg_s v, input int idle);
        prc_cfg_s w;
        w = v;
        w.fb_div3 = v.fb_div3 & ~AVS_RAILS;
        repeat (idle) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        o_cfg_wr    <= 1'b1;
        o_cfg_wdata <= w;
        @(posedge i_ref_clk);
        o_cfg_wr    <= 1'b0;
        o_cfg_wdata <= ~w;
    endtask : write
endmodule : prc_host_model

// ---- tb/prc_rail_config_sva.sv ----
// Checker of the rail configuration block, bound to its top ports.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/10ps
module prc_rail_config_chk
    import prc_pkg::*;
(
    input wire logic             i_ref_clk,
    input wire logic             i_rst_b,
    input wire prc_cfg_s         i_fuse_cfg,
    input wire logic             i_enable_sync,
    input wire logic             i_mp_in,
    input wire prc_cfg_s         o_cfg,
    input wire logic [3:0]       o_rail_run,
    input wire logic [3:0]       o_fb_div3,
    input wire logic [3:0][10:0] o_ref_target_mv,
    input wire logic [3:0][10:0] o_ref_mv,
    input wire logic [3:0][12:0] o_vout_mv,
    input wire logic [3:0][14:0] o_ilim_ma,
    input wire logic [13:0]      o_uvlo_rise_mv,
    input wire logic [10:0]      o_switch_khz,
    input wire logic [6:0]       o_slave_addr,
    input wire logic             o_mp_out,
    input wire logic             o_mp_oe
);
    // Expected decodes of thresholds, rates and valley limits
    localparam logic [13:0] UV [4] = '{14'h0DAC, 14'h1194, 14'h16A8, 14'h2134};
    localparam logic [10:0] KHZ [4] = '{11'h215, 11'h320, 11'h424, 11'h640};
    localparam logic [13:0] LIM [4] = '{14'h07D0, 14'h0BB8, 14'h1068, 14'h1388};
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    property p_ref;
        o_ref_target_mv[0] == 11'h226 + 11'h00A * o_cfg.ref_code[0];
    endproperty
    a_ref: assert property (p_ref) else $error("ref target");
    property p_vout;
        o_fb_div3[0] == o_cfg.fb_div3[0] &&
        o_vout_mv[0] == (o_fb_div3[0] ? 13'h0003 * o_ref_mv[0] : {2'h0, o_ref_mv[0]});
    endproperty
    a_vout: assert property (p_vout) else $error("vout scale");
    property p_ramp;
        $changed(o_ref_mv[0]) && $past(o_ref_mv[0]) != 11'h000 |->
        (o_ref_mv[0] == $past(o_ref_mv[0]) + 11'h001 ||
         o_ref_mv[0] + 11'h001 == $past(o_ref_mv[0])) ##1 $stable(o_ref_mv[0]) [*8];
    endproperty
    a_ramp: assert property (p_ramp) else $error("ref step");
    property p_decode;
        o_uvlo_rise_mv == UV[o_cfg.uvlo_sel] && o_switch_khz == KHZ[o_cfg.switch_rate_select];
    endproperty
    a_decode: assert property (p_decode) else $error("decode");
    property p_addr;
        o_slave_addr[5:1] == o_cfg.addr_hi &&
        o_slave_addr[0] == (o_cfg.multipin_function_select == 2'h0 && i_mp_in);
    endproperty
    a_addr: assert property (p_addr) else $error("address");
    property p_port;
        o_cfg.multipin_function_select == 2'h2 |->
        !o_mp_out && o_mp_oe == !o_cfg.output_port_level;
    endproperty
    a_port: assert property (p_port) else $error("port pin");
    property p_gang12;
        o_cfg.gang12 |-> o_ilim_ma[1] == {LIM[o_cfg.ilim_sel[0]], 1'b0} &&
        o_ref_target_mv[1] == o_ref_target_mv[0];
    endproperty
    a_gang12: assert property (p_gang12) else $error("gang 1/2");
    property p_gang34;
        o_cfg.gang34 |-> o_ilim_ma[3] == {LIM[o_cfg.ilim_sel[2]], 1'b0} &&
        o_ilim_ma[2] == o_ilim_ma[3];
    endproperty
    a_gang34: assert property (p_gang34) else $error("gang 3/4");
    property p_sd_all;
        $fell(i_enable_sync) && !o_cfg.sd_reverse && o_rail_run != 4'h0 |->
        ##1 o_rail_run == 4'h0;
    endproperty
    a_sd_all: assert property (p_sd_all) else $error("shutdown");
    property p_load;
        $rose(i_rst_b) |-> ##1 o_cfg == $past(i_fuse_cfg);
    endproperty
    a_load: assert property (p_load) else $error("fuse load");
endmodule : prc_rail_config_chk

bind prc_rail_config prc_rail_config_chk u_prc_rail_config_chk (.i_ref_clk, .i_rst_b,
    .i_fuse_cfg, .i_enable_sync, .i_mp_in, .o_cfg, .o_rail_run, .o_fb_div3,
    .o_ref_target_mv, .o_ref_mv, .o_vout_mv, .o_ilim_ma, .o_uvlo_rise_mv,
    .o_switch_khz, .o_slave_addr, .o_mp_out, .o_mp_oe);

// ---- tb/prc_rail_config_tb.sv ----
// Self-checking bench of the rail configuration block.
// Assumes the host model and the bound checker; 250 MHz clock.
`timescale 1ns/10ps
module prc_rail_config_tb;
    import prc_pkg::*;
    typedef struct packed {
        logic [1:0]  uv;
        logic [1:0]  fr;
        logic [6:0]  rc;
        logic [13:0] ev;
        logic [10:0] ek;
        logic [10:0] er;
    } prc_row_s;
    logic             i_ref_clk, i_rst_b, i_cfg_wr, i_enable_sync, i_mp_in;
    logic             o_power_good, o_mp_out, o_mp_oe, v;
    prc_cfg_s         i_fuse_cfg, i_cfg_wdata, o_cfg, c;
    logic [3:0]       i_rail_ok, o_rail_run, o_fb_div3;
    logic [3:0][10:0] o_ref_target_mv, o_ref_mv;
    logic [3:0][12:0] o_vout_mv;
    logic [3:0][14:0] o_ilim_ma;
    logic [13:0]      o_uvlo_rise_mv;
    logic [10:0]      o_switch_khz;
    logic [6:0]       o_slave_addr;
    int               failures = 0, n_compared = 0, n;
    prc_row_s         rows [4] = '{'{2'h0, 2'h3, 7'h00, 14'h0DAC, 11'h640, 11'h226},
                                   '{2'h1, 2'h2, 7'h01, 14'h1194, 11'h424, 11'h230},
                                   '{2'h2, 2'h1, 7'h7F, 14'h16A8, 11'h320, 11'h71C},
                                   '{2'h3, 2'h0, 7'h40, 14'h2134, 11'h215, 11'h4A6}};
    logic [7:0]       half [4] = '{8'hEA, 8'h9C, 8'h75, 8'h4E};

    // Delay code 4 keeps its full length and is checked for not firing early
    prc_rail_config #(.SLOT_CYC(32'h4), .PG_CYC_0(32'h5), .PG_CYC_1(32'hA),
        .PG_CYC_2(32'hF), .PG_CYC_3(32'h14)) u_prc_rail_config (
        .i_ref_clk, .i_rst_b, .i_fuse_cfg, .i_cfg_wr, .i_cfg_wdata, .i_enable_sync,
        .i_rail_ok, .i_mp_in, .o_cfg, .o_rail_run, .o_fb_div3, .o_ref_target_mv,
        .o_ref_mv, .o_vout_mv, .o_ilim_ma, .o_uvlo_rise_mv, .o_switch_khz,
        .o_slave_addr, .o_power_good, .o_mp_out, .o_mp_oe);
    prc_host_model u_prc_host_model (.i_ref_clk, .o_cfg_wr(i_cfg_wr), .o_cfg_wdata(i_cfg_wdata));

    // Clock and watchdog
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #100000;
        failures++;
        $display("[FAIL] %0t watchdog", $time);
        stop_test();
    end

    // Range compare; an unknown never passes
    task automatic chk(input logic [63:0] got, lo, hi, input string m);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t %s got %0h", $time, m, got);
        end
    endtask : chk
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask : tick
    task automatic wr(input prc_cfg_s x, input int idle);
        u_prc_host_model.write(x, idle);
        #1;
    endtask : wr
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        i_rst_b = 1'b0;
        i_enable_sync = 1'b0;
        i_rail_ok = 4'h0;
        i_mp_in = 1'b1;
        i_fuse_cfg = '0;
        i_fuse_cfg.ref_code[0] = 7'h17;
        i_fuse_cfg.rail_enable = 4'hF;
        i_fuse_cfg.addr_hi = 5'h08;
        i_fuse_cfg.multipin_function_select = 2'h2;
        i_fuse_cfg.ilim_sel = 8'h55;
        repeat (12) @(posedge i_ref_clk);
        chk(o_cfg, 0, 0, "reset config");
        chk({o_rail_run, o_mp_oe, o_power_good}, 0, 0, "reset outputs");
        i_rst_b <= 1'b1;
        repeat (2) tick();
        chk(o_cfg, i_fuse_cfg, i_fuse_cfg, "fuse load");
        chk(o_ref_mv[0], 11'h30C, 11'h30C, "no ramp on load");
        chk(o_mp_oe, 1, 1, "port default");
        c = i_fuse_cfg;
        c.ref_code[0] = 7'h18;
        wr(c, 0);
        for (n = 0; o_ref_mv[0] !== 11'h316 && n < 1200; n++) tick();
        chk(n, 864, 961, "ramp time");
        c.fb_div3 = 4'h1;
        c.gang12 = 1'b1;
        c.gang34 = 1'b1;
        c.ilim_sel = 8'h36;
        c.ref_code[1] = 7'h7F;
        wr(c, 2);
        chk(o_vout_mv[0], 13'h0942, 13'h0942, "divide");
        chk({o_fb_div3[1], o_ref_target_mv[1]}, 12'hB16, 12'hB16, "follower");
        chk(o_ilim_ma[1], 15'h20D0, 15'h20D0, "limit 1/2");
        chk(o_ilim_ma[3], 15'h2710, 15'h2710, "limit 3/4");
        // Decode table, one row a write
        for (int i = 0; i < 4; i++) begin
            c = i_fuse_cfg;
            c.uvlo_sel = rows[i].uv;
            c.switch_rate_select = rows[i].fr;
            c.ref_code = {4{rows[i].rc}};
            wr(c, 0);
            chk(o_uvlo_rise_mv, rows[i].ev, rows[i].ev, "uvlo");
            chk(o_switch_khz, rows[i].ek, rows[i].ek, "rate");
            chk(o_ref_target_mv[3], rows[i].er, rows[i].er, "target");
        end
        // Power-up sequence, enable mask, power-good delays
        c.multipin_function_select = 2'h1;
        wr(c, 0);
        i_enable_sync <= 1'b1;
        for (n = 0; o_rail_run !== 4'hF && n < 100; n++) tick();
        chk(n, 19, 23, "power up");
        c.rail_enable = 4'hB;
        wr(c, 0);
        chk(o_rail_run, 4'hB, 4'hB, "enable mask");
        c.rail_enable = 4'hF;
        for (int k = 0; k < 5; k++) begin
            // Codes 4, 0, 1, 2, 3 in turn; code 4 must stay low for the whole wait
            c.good_indicator_delay = 3'((k + 4) % 5);
            wr(c, 0);
            i_rail_ok <= 4'h0;
            repeat (4) tick();
            chk(o_mp_oe, 1, 1, "good pin low");
            i_rail_ok <= 4'hF;
            for (n = 0; o_power_good !== 1'b1 && n < 60; n++) tick();
            chk(n, (k == 0) ? 60 : 5 * k, (k == 0) ? 60 : 5 * k + 4, "good delay");
        end
        tick();
        chk(o_mp_oe, 0, 0, "good pin free");
        // Reverse-order shutdown, then all-at-once shutdown
        c.sd_reverse = 1'b1;
        wr(c, 0);
        i_enable_sync <= 1'b0;
        for (n = 0; o_rail_run === 4'hF && n < 20; n++) tick();
        chk(o_rail_run, 4'h7, 4'h7, "last rail first");
        for (n = 0; o_rail_run !== 4'h0 && n < 40; n++) tick();
        chk(o_rail_run, 0, 0, "reverse done");
        c.sd_reverse = 1'b0;
        wr(c, 0);
        i_enable_sync <= 1'b1;
        for (n = 0; o_rail_run !== 4'hF && n < 100; n++) tick();
        chk(n, 19, 23, "power up again");
        i_enable_sync <= 1'b0;
        tick();
        chk(o_rail_run, 0, 0, "all off");
        // Port pin, address input, sync clock
        c.multipin_function_select = 2'h2;
        wr(c, 0);
        tick();
        chk(o_mp_oe, 1, 1, "port low");
        c.output_port_level = 1'b1;
        wr(c, 0);
        tick();
        chk(o_mp_oe, 0, 0, "port released");
        c.multipin_function_select = 2'h0;
        c.output_port_level = 1'b0;
        c.addr_hi = 5'h13;
        wr(c, 0);
        tick();
        chk({o_mp_oe, o_slave_addr}, 8'h67, 8'h67, "address in");
        i_mp_in <= 1'b0;
        tick();
        chk(o_slave_addr, 7'h66, 7'h66, "address bit");
        c.multipin_function_select = 2'h3;
        for (int k = 0; k < 4; k++) begin
            c.switch_rate_select = 2'(k);
            wr(c, 0);
            v = o_mp_oe;
            for (n = 0; o_mp_oe === v && n < 600; n++) tick();
            v = o_mp_oe;
            for (n = 0; o_mp_oe === v && n < 600; n++) tick();
            chk(n, half[k] - 1, half[k] + 1, "sync half");
        end
        stop_test();
    end
endmodule : prc_rail_config_tb
